//--- rtl/mgmt_filter_pkg.sv
// Constants, register map and packed carriers for the management filter register bank.
// Assumes a 16-bit byte address on every register port and one 50 MHz core clock.
package mgmt_filter_pkg;

    localparam logic [15:0] VLAN_BASE = 16'h5010;
    localparam logic [15:0] PORT_BASE = 16'h5030;
    localparam logic [15:0] ETYPE_BASE = 16'h5060;
    localparam logic [15:0] CTRL_ADDR = 16'h5820;
    localparam logic [15:0] EXCL_ADDR = 16'h5864;
    localparam logic [15:0] DEC_BASE = 16'h5890;
    localparam logic [15:0] DEC_EXT_BASE = 16'h5930;

    localparam int VLAN_COUNT = 8;
    localparam int PORT_REG_COUNT = 8;
    localparam int ETYPE_COUNT = 4;
    localparam int DEC_COUNT = 8;
    localparam int VID_WIDTH = 12;
    localparam int EXT_ETYPE_WIDTH = 4;

    localparam int FIRMWARE_RESET_SEEN_BIT = 14;
    localparam int ISOLATE_BIT = 15;
    localparam int PORT_RESET_BIT = 16;
    localparam int TRAFFIC_BIT = 17;
    localparam int PHY_HOLD_BIT = 18;
    localparam int CSUM_BIT = 23;
    localparam int IPV4_MODE_BIT = 24;
    localparam int FIXED_NET_BIT = 25;
    localparam int NET_TYPE_BIT = 26;

    localparam int UC_AND_LSB = 0;
    localparam int BC_AND_BIT = 4;
    localparam int VLAN_AND_LSB = 5;
    localparam int IPV4_AND_LSB = 13;
    localparam int IPV6_AND_LSB = 17;
    localparam int UC_OR_LSB = 21;
    localparam int BC_OR_BIT = 25;
    localparam int MC_AND_BIT = 26;
    localparam int ARP_REQ_BIT = 27;
    localparam int ARP_RSP_BIT = 28;
    localparam int ND_BIT = 29;
    localparam int PORT_A_BIT = 30;
    localparam int PORT_B_BIT = 31;
    localparam int ETYPE_POLARITY_BIT = 30;

    localparam logic [7:0] ND_TYPE_FIRST = 8'h86;
    localparam logic [7:0] ND_TYPE_LAST = 8'h89;
    localparam logic [15:0] FIXED_PORT_A = 16'h0298;
    localparam logic [15:0] FIXED_PORT_B = 16'h026f;
    localparam logic [7:0] ISOLATE_ERR_CODE = 8'h0e;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] EXCL_RESET = 8'h00;
    localparam logic [7:0] ERR_CODE_RESET = 8'h00;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_VLAN, SEL_PORT, SEL_ETYPE, SEL_CTRL, SEL_EXCL, SEL_DEC, SEL_DEC_EXT
    } reg_sel_t;

    typedef struct packed {
        reg_sel_t sel;
        logic [2:0] idx;
    } reg_decode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] uc_hit;
        logic bcast;
        logic mcast;
        logic vlan_tagged;
        logic [11:0] vlan_id;
        logic [3:0] ipv4_hit;
        logic [3:0] ipv6_hit;
        logic arp_req;
        logic arp_rsp;
        logic icmpv6;
        logic [7:0] icmpv6_type;
        logic l4_valid;
        logic [15:0] dst_port;
        logic [15:0] ethertype;
        logic csum_ok;
    } rx_pkt_t;

    typedef struct packed {
        logic valid;
        logic to_mgmt;
        logic withhold_host;
        logic [7:0] hits;
    } decision_t;

endpackage

//--- rtl/mgmt_packet_filter_regs.sv
// Management register bank and receive decision filters for the controller's BMC path.
// Assumes all inputs are synchronous to i_core_clk and that i_resetn is the supply-valid reset.
//
// Overview of operation
// - BMC reads and writes; host writes are blocked.
// - Eight 12-bit VLAN identifiers compared against tags.
// - Even port low half, odd port high.
// - Port registers cleared only by power reset.
// - Four 16-bit EtherType values compared per packet.
// - Firmware reset sets flag; BMC zero clears.
// - Isolate discards host writes, still completing them.
// - Isolate command raises interrupt, loads code 0x0E.
// - Port reset by BMC sets its flag.
// - Traffic enable clear blocks both BMC directions.
// - PHY hold bit blocks resets; permit gates writes.
// - Checksum gate passes only good checksum packets.
// - Mode bit picks four IPv4 or IPv6.
// - Fixed net type selects untagged or tagged.
// - Exclusive bit withholds forwarded packets from host.
// - Exclusive mask cleared by power and firmware reset.
// - AND section field layout of decision words.
// - IPv4 or IPv6 enables chosen by mode.
// - OR section field layout of decision words.
// - Neighbor discovery accepts types 0x86 to 0x89.
// - Multicast AND condition excludes broadcast frames.
// - Decision words loaded from EEPROM, not constants.
// - Extended words hold EtherType AND enables 3:0.
`timescale 1ns/1ps

module mgmt_packet_filter_regs (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // BMC register port
    input wire mgmt_filter_pkg::reg_req_t i_bmc_req,
    output logic o_bmc_ack,
    output logic [31:0] o_bmc_rdata,
    // Host register port
    input wire mgmt_filter_pkg::reg_req_t i_host_req,
    output logic o_host_ack,
    output logic [31:0] o_host_rdata,
    output logic o_host_wr_discard,
    // EEPROM initial value load and PHY hold write permit
    input wire logic i_eeprom_wr,
    input wire logic [15:0] i_eeprom_addr,
    input wire logic [31:0] i_eeprom_data,
    output logic o_eeprom_ready,
    input wire logic i_phy_hold_permit,
    // Management events
    input wire logic i_firmware_reset_seen,
    input wire logic i_port_reset,
    input wire logic i_isolate_cmd,
    input wire logic i_isolate_state,
    output logic o_mgmt_interrupt_cause,
    output logic [7:0] o_fw_extended_error_code,
    // Receive decision
    input wire mgmt_filter_pkg::rx_pkt_t i_rx_pkt,
    output mgmt_filter_pkg::decision_t o_decision,
    output logic [15:0] o_port_hits,
    // BMC transmit gate
    input wire logic i_bmc_tx_valid,
    output logic o_bmc_tx_valid,
    // PHY control gate
    input wire logic i_phy_reset_req,
    input wire logic i_phy_power_req,
    output logic o_phy_reset,
    output logic o_phy_power_req,
    output logic o_phy_hold_link
);
    import mgmt_filter_pkg::*;

    localparam logic [31:0] CTRL_RW_MASK = (32'h1 << TRAFFIC_BIT) | (32'h1 << CSUM_BIT)
        | (32'h1 << IPV4_MODE_BIT) | (32'h1 << FIXED_NET_BIT) | (32'h1 << NET_TYPE_BIT);

    logic [11:0] vlan_id_match_reg [VLAN_COUNT];
    logic [11:0] next_vlan_id_match_reg [VLAN_COUNT];
    logic [31:0] port_pair_match_reg [PORT_REG_COUNT];
    logic [31:0] next_port_pair_match_reg [PORT_REG_COUNT];
    logic [16:0] ethertype_match_reg [ETYPE_COUNT];
    logic [16:0] next_ethertype_match_reg [ETYPE_COUNT];
    logic [31:0] management_control_reg;
    logic [31:0] next_management_control_reg;
    logic [7:0] exclusive_mask_reg;
    logic [7:0] next_exclusive_mask_reg;
    logic [31:0] decision_filter_word [DEC_COUNT];
    logic [31:0] next_decision_filter_word [DEC_COUNT];
    logic [3:0] decision_filter_ext_word [DEC_COUNT];
    logic [3:0] next_decision_filter_ext_word [DEC_COUNT];

    logic bmc_ack;
    logic next_bmc_ack;
    logic [31:0] bmc_rdata;
    logic [31:0] next_bmc_rdata;
    logic host_ack;
    logic next_host_ack;
    logic [31:0] host_rdata;
    logic [31:0] next_host_rdata;
    logic irq_pulse;
    logic next_irq_pulse;
    logic [7:0] err_code;
    logic [7:0] next_err_code;
    decision_t decision;
    decision_t next_decision;
    logic [15:0] port_hits;
    logic [15:0] next_port_hits;
    logic bmc_tx_valid;
    logic next_bmc_tx_valid;
    logic phy_reset;
    logic next_phy_reset;
    logic phy_power_req;
    logic next_phy_power_req;

    reg_decode_t wr_dec;
    logic [31:0] wr_data;
    logic [7:0] vlan_hit;
    logic [3:0] etype_hit;
    logic nd_hit;
    logic port_a_hit;
    logic port_b_hit;
    logic gate_ok;

    function automatic logic in_window(input logic [15:0] a, input logic [15:0] base,
                                       input int count);
        logic [15:0] top;
        top = base + 16'(4 * count);
        in_window = (a >= base) && (a < top) && (a[1:0] == 2'b00);
    endfunction

    function automatic reg_decode_t decode(input logic [15:0] a);
        reg_decode_t d;
        logic [15:0] off;
        d.sel = SEL_NONE;
        off = 16'h0000;
        if (in_window(a, VLAN_BASE, VLAN_COUNT)) begin
            d.sel = SEL_VLAN;
            off = a - VLAN_BASE;
        end else if (in_window(a, PORT_BASE, PORT_REG_COUNT)) begin
            d.sel = SEL_PORT;
            off = a - PORT_BASE;
        end else if (in_window(a, ETYPE_BASE, ETYPE_COUNT)) begin
            d.sel = SEL_ETYPE;
            off = a - ETYPE_BASE;
        end else if (a == CTRL_ADDR) begin
            d.sel = SEL_CTRL;
        end else if (a == EXCL_ADDR) begin
            d.sel = SEL_EXCL;
        end else if (in_window(a, DEC_BASE, DEC_COUNT)) begin
            d.sel = SEL_DEC;
            off = a - DEC_BASE;
        end else if (in_window(a, DEC_EXT_BASE, DEC_COUNT)) begin
            d.sel = SEL_DEC_EXT;
            off = a - DEC_EXT_BASE;
        end
        d.idx = off[4:2];
        decode = d;
    endfunction

    // Reserved bits read as zero; unmapped addresses read as zero.
    function automatic logic [31:0] read_word(input reg_decode_t d);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (d.sel)
            SEL_NONE: r = 32'h0000_0000;
            SEL_VLAN: r = {20'h00000, vlan_id_match_reg[d.idx]};
            SEL_PORT: r = port_pair_match_reg[d.idx];
            SEL_ETYPE: begin
                r[15:0] = ethertype_match_reg[d.idx[1:0]][15:0];
                r[ETYPE_POLARITY_BIT] = ethertype_match_reg[d.idx[1:0]][16];
            end
            SEL_CTRL: begin
                r = management_control_reg;
                r[ISOLATE_BIT] = i_isolate_state;
            end
            SEL_EXCL: r = {24'h000000, exclusive_mask_reg};
            SEL_DEC: r = decision_filter_word[d.idx];
            SEL_DEC_EXT: r = {28'h0000000, decision_filter_ext_word[d.idx]};
        endcase
        read_word = r;
    endfunction

    // A group condition holds when nothing in it is enabled or an enabled entry matches.
    function automatic logic group_ok(input logic [7:0] en, input logic [7:0] hit);
        group_ok = (en == 8'h00) || ((en & hit) != 8'h00);
    endfunction

    // Port values are held in network byte order: first wire byte in the low lane.
    function automatic logic [15:0] wire_to_host(input logic [15:0] v);
        wire_to_host = {v[7:0], v[15:8]};
    endfunction

    // Register writes: BMC first, EEPROM load when the BMC is not writing, host never.
    always_comb begin
        wr_dec = decode(16'h0000);
        wr_data = 32'h0000_0000;
        if (i_bmc_req.wr) begin
            wr_dec = decode(i_bmc_req.addr);
            wr_data = i_bmc_req.wdata;
        end else if (i_eeprom_wr) begin
            wr_dec = decode(i_eeprom_addr);
            wr_data = i_eeprom_data;
        end
        for (int i = 0; i < VLAN_COUNT; i++) begin
            next_vlan_id_match_reg[i] = vlan_id_match_reg[i];
            if (wr_dec.sel == SEL_VLAN && wr_dec.idx == 3'(i)) begin
                next_vlan_id_match_reg[i] = wr_data[VID_WIDTH-1:0];
            end
        end
        for (int i = 0; i < PORT_REG_COUNT; i++) begin
            next_port_pair_match_reg[i] = port_pair_match_reg[i];
            if (wr_dec.sel == SEL_PORT && wr_dec.idx == 3'(i)) begin
                next_port_pair_match_reg[i] = wr_data;
            end
        end
        for (int i = 0; i < ETYPE_COUNT; i++) begin
            next_ethertype_match_reg[i] = ethertype_match_reg[i];
            if (wr_dec.sel == SEL_ETYPE && wr_dec.idx == 3'(i)) begin
                next_ethertype_match_reg[i] = {wr_data[ETYPE_POLARITY_BIT], wr_data[15:0]};
            end
        end
        for (int i = 0; i < DEC_COUNT; i++) begin
            next_decision_filter_word[i] = decision_filter_word[i];
            next_decision_filter_ext_word[i] = decision_filter_ext_word[i];
            if (wr_dec.sel == SEL_DEC && wr_dec.idx == 3'(i)) begin
                next_decision_filter_word[i] = wr_data;
            end
            if (wr_dec.sel == SEL_DEC_EXT && wr_dec.idx == 3'(i)) begin
                next_decision_filter_ext_word[i] = wr_data[EXT_ETYPE_WIDTH-1:0];
            end
        end
        next_exclusive_mask_reg = exclusive_mask_reg;
        if (wr_dec.sel == SEL_EXCL) begin
            next_exclusive_mask_reg = wr_data[7:0];
        end
        if (i_firmware_reset_seen) begin
            next_exclusive_mask_reg = EXCL_RESET;
        end
        next_management_control_reg = management_control_reg;
        if (wr_dec.sel == SEL_CTRL) begin
            next_management_control_reg = (management_control_reg & ~CTRL_RW_MASK)
                | (wr_data & CTRL_RW_MASK);
            if (i_phy_hold_permit) begin
                next_management_control_reg[PHY_HOLD_BIT] = wr_data[PHY_HOLD_BIT];
            end
            if (!wr_data[FIRMWARE_RESET_SEEN_BIT]) begin
                next_management_control_reg[FIRMWARE_RESET_SEEN_BIT] = 1'b0;
            end
            if (!wr_data[PORT_RESET_BIT]) begin
                next_management_control_reg[PORT_RESET_BIT] = 1'b0;
            end
        end
        if (i_firmware_reset_seen) begin
            next_management_control_reg[FIRMWARE_RESET_SEEN_BIT] = 1'b1;
        end
        if (i_port_reset) begin
            next_management_control_reg[PORT_RESET_BIT] = 1'b1;
        end
        next_management_control_reg[ISOLATE_BIT] = 1'b0;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < VLAN_COUNT; i++) begin
                vlan_id_match_reg[i] <= REG_RESET[VID_WIDTH-1:0];
            end
            for (int i = 0; i < PORT_REG_COUNT; i++) begin
                port_pair_match_reg[i] <= REG_RESET;
            end
            for (int i = 0; i < ETYPE_COUNT; i++) begin
                ethertype_match_reg[i] <= REG_RESET[16:0];
            end
            for (int i = 0; i < DEC_COUNT; i++) begin
                decision_filter_word[i] <= REG_RESET;
                decision_filter_ext_word[i] <= REG_RESET[EXT_ETYPE_WIDTH-1:0];
            end
            management_control_reg <= CTRL_RESET;
            exclusive_mask_reg <= EXCL_RESET;
        end else begin
            vlan_id_match_reg <= next_vlan_id_match_reg;
            port_pair_match_reg <= next_port_pair_match_reg;
            ethertype_match_reg <= next_ethertype_match_reg;
            decision_filter_word <= next_decision_filter_word;
            decision_filter_ext_word <= next_decision_filter_ext_word;
            management_control_reg <= next_management_control_reg;
            exclusive_mask_reg <= next_exclusive_mask_reg;
        end
    end

    // Register read answers, management events and the PHY and transmit gates.
    always_comb begin
        next_bmc_ack = i_bmc_req.rd | i_bmc_req.wr;
        next_bmc_rdata = bmc_rdata;
        if (i_bmc_req.rd) begin
            next_bmc_rdata = read_word(decode(i_bmc_req.addr));
        end
        next_host_ack = i_host_req.rd | i_host_req.wr;
        next_host_rdata = host_rdata;
        if (i_host_req.rd) begin
            next_host_rdata = read_word(decode(i_host_req.addr));
        end
        next_irq_pulse = i_isolate_cmd;
        next_err_code = err_code;
        if (i_isolate_cmd) begin
            next_err_code = ISOLATE_ERR_CODE;
        end
        next_bmc_tx_valid = i_bmc_tx_valid & management_control_reg[TRAFFIC_BIT];
        next_phy_reset = i_phy_reset_req & ~management_control_reg[PHY_HOLD_BIT];
        next_phy_power_req = i_phy_power_req & ~management_control_reg[PHY_HOLD_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bmc_ack <= 1'b0;
            bmc_rdata <= REG_RESET;
            host_ack <= 1'b0;
            host_rdata <= REG_RESET;
            irq_pulse <= 1'b0;
            err_code <= ERR_CODE_RESET;
            bmc_tx_valid <= 1'b0;
            phy_reset <= 1'b0;
            phy_power_req <= 1'b0;
        end else begin
            bmc_ack <= next_bmc_ack;
            bmc_rdata <= next_bmc_rdata;
            host_ack <= next_host_ack;
            host_rdata <= next_host_rdata;
            irq_pulse <= next_irq_pulse;
            err_code <= next_err_code;
            bmc_tx_valid <= next_bmc_tx_valid;
            phy_reset <= next_phy_reset;
            phy_power_req <= next_phy_power_req;
        end
    end

    // Receive decision: match vectors, per-filter AND/OR evaluation and global gates.
    always_comb begin
        logic [31:0] w;
        logic [7:0] or_en;
        logic [7:0] or_hit;
        logic and_ok;
        logic or_ok;
        logic ip_ok;
        w = 32'h0000_0000;
        or_en = 8'h00;
        or_hit = 8'h00;
        and_ok = 1'b0;
        or_ok = 1'b0;
        ip_ok = 1'b0;
        for (int i = 0; i < VLAN_COUNT; i++) begin
            vlan_hit[i] = i_rx_pkt.vlan_tagged && (i_rx_pkt.vlan_id == vlan_id_match_reg[i]);
        end
        for (int i = 0; i < ETYPE_COUNT; i++) begin
            etype_hit[i] = (i_rx_pkt.ethertype == ethertype_match_reg[i][15:0]);
        end
        for (int i = 0; i < PORT_REG_COUNT; i++) begin
            next_port_hits[2*i] = i_rx_pkt.l4_valid
                && (wire_to_host(port_pair_match_reg[i][15:0]) == i_rx_pkt.dst_port);
            next_port_hits[2*i+1] = i_rx_pkt.l4_valid
                && (wire_to_host(port_pair_match_reg[i][31:16]) == i_rx_pkt.dst_port);
        end
        nd_hit = i_rx_pkt.icmpv6 && (i_rx_pkt.icmpv6_type >= ND_TYPE_FIRST)
            && (i_rx_pkt.icmpv6_type <= ND_TYPE_LAST);
        port_a_hit = i_rx_pkt.l4_valid && (i_rx_pkt.dst_port == FIXED_PORT_A);
        port_b_hit = i_rx_pkt.l4_valid && (i_rx_pkt.dst_port == FIXED_PORT_B);
        gate_ok = management_control_reg[TRAFFIC_BIT]
            && (!management_control_reg[CSUM_BIT] || i_rx_pkt.csum_ok)
            && (!management_control_reg[FIXED_NET_BIT]
                || (management_control_reg[NET_TYPE_BIT] == i_rx_pkt.vlan_tagged));
        next_decision.hits = 8'h00;
        for (int n = 0; n < DEC_COUNT; n++) begin
            w = decision_filter_word[n];
            // The last IP slots are four IPv4 entries or four IPv6 entries.
            if (management_control_reg[IPV4_MODE_BIT]) begin
                ip_ok = group_ok(8'(w[IPV4_AND_LSB +: 4]), 8'(i_rx_pkt.ipv4_hit));
            end else begin
                ip_ok = group_ok(8'(w[IPV6_AND_LSB +: 4]), 8'(i_rx_pkt.ipv6_hit));
            end
            and_ok = group_ok(8'(w[UC_AND_LSB +: 2]), 8'(i_rx_pkt.uc_hit))
                && (!w[BC_AND_BIT] || i_rx_pkt.bcast)
                && group_ok(w[VLAN_AND_LSB +: 8], vlan_hit)
                && ip_ok
                && (!w[MC_AND_BIT] || (i_rx_pkt.mcast && !i_rx_pkt.bcast))
                && group_ok(8'(decision_filter_ext_word[n]), 8'(etype_hit));
            or_en = {w[UC_OR_LSB +: 2], w[BC_OR_BIT], w[ARP_REQ_BIT], w[ARP_RSP_BIT],
                w[ND_BIT], w[PORT_A_BIT], w[PORT_B_BIT]};
            or_hit = {i_rx_pkt.uc_hit, i_rx_pkt.bcast, i_rx_pkt.arp_req, i_rx_pkt.arp_rsp,
                nd_hit, port_a_hit, port_b_hit};
            or_ok = (or_en == 8'h00) || ((or_en & or_hit) != 8'h00);
            next_decision.hits[n] = ((w != 32'h0000_0000)
                || (decision_filter_ext_word[n] != 4'h0)) && and_ok && or_ok;
        end
        next_decision.valid = i_rx_pkt.valid;
        next_decision.to_mgmt = i_rx_pkt.valid && gate_ok && (next_decision.hits != 8'h00);
        next_decision.withhold_host = next_decision.to_mgmt
            && ((next_decision.hits & exclusive_mask_reg) != 8'h00);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            decision <= '0;
            port_hits <= 16'h0000;
        end else begin
            decision <= next_decision;
            port_hits <= next_port_hits;
        end
    end

    assign o_bmc_ack = bmc_ack;
    assign o_bmc_rdata = bmc_rdata;
    assign o_host_ack = host_ack;
    assign o_host_rdata = host_rdata;
    assign o_host_wr_discard = i_isolate_state;
    assign o_eeprom_ready = ~i_bmc_req.wr;
    assign o_mgmt_interrupt_cause = irq_pulse;
    assign o_fw_extended_error_code = err_code;
    assign o_decision = decision;
    assign o_port_hits = port_hits;
    assign o_bmc_tx_valid = bmc_tx_valid;
    assign o_phy_reset = phy_reset;
    assign o_phy_power_req = phy_power_req;
    assign o_phy_hold_link = management_control_reg[PHY_HOLD_BIT];

endmodule

//--- test/mgmt_filter_asserts.sv
// Port checker for the management filter bank.
// Assumes one core clock and the bind at the foot.
`timescale 1ns/1ps
module mgmt_filter_asserts (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire mgmt_filter_pkg::reg_req_t i_bmc_req,
    input wire mgmt_filter_pkg::reg_req_t i_host_req,
    input wire logic i_isolate_cmd,
    input wire logic i_bmc_tx_valid,
    input wire logic i_phy_reset_req,
    input wire mgmt_filter_pkg::rx_pkt_t i_rx_pkt,
    input wire logic o_bmc_ack,
    input wire logic o_host_ack,
    input wire logic o_mgmt_interrupt_cause,
    input wire logic [7:0] o_fw_extended_error_code,
    input wire mgmt_filter_pkg::decision_t o_decision,
    input wire logic o_bmc_tx_valid,
    input wire logic o_phy_reset,
    input wire logic o_phy_hold_link
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_iso_done;
        o_mgmt_interrupt_cause && o_fw_extended_error_code == 8'h0e;
    endsequence
    AST_BMC_ACK: assert property ((i_bmc_req.wr || i_bmc_req.rd) |=> o_bmc_ack)
        else $error("bmc ack missing");
    AST_HOST_ACK: assert property ((i_host_req.wr || i_host_req.rd) |=> o_host_ack)
        else $error("host ack missing");
    AST_ISO: assert property (i_isolate_cmd |=> s_iso_done)
        else $error("isolate answer wrong");
    AST_IRQ_CAUSE: assert property (o_mgmt_interrupt_cause |-> $past(i_isolate_cmd))
        else $error("stray interrupt cause");
    AST_TX_GATE: assert property (o_bmc_tx_valid |-> $past(i_bmc_tx_valid))
        else $error("stray bmc transmit");
    AST_PHY_HOLD: assert property (o_phy_reset |-> $past(i_phy_reset_req)
        && !$past(o_phy_hold_link)) else $error("phy reset leaked");
    AST_DEC_VALID: assert property (o_decision.valid == $past(i_rx_pkt.valid))
        else $error("decision timing wrong");
    AST_DEC_HITS: assert property (o_decision.to_mgmt |-> o_decision.hits != 8'h00)
        else $error("forward without hit");
    AST_WITHHOLD: assert property (o_decision.withhold_host |-> o_decision.to_mgmt)
        else $error("withhold without forward");
endmodule
bind mgmt_packet_filter_regs mgmt_filter_asserts u_mgmt_filter_asserts (.*);

//--- test/mgmt_rx_source.sv
// Far-side traffic source presenting one packet per request.
// Assumes the bench raises i_send for one cycle per packet.
`timescale 1ns/1ps
module mgmt_rx_source (
    // Request from the bench
    input wire logic i_send,
    input wire mgmt_filter_pkg::rx_pkt_t i_pkt,
    // Line towards the filter
    output mgmt_filter_pkg::rx_pkt_t o_pkt
);
    import mgmt_filter_pkg::*;
    // Idle attributes are inverted so stale values never look real.
    assign o_pkt = i_send ? i_pkt : {1'b0, ~i_pkt[$bits(rx_pkt_t)-2:0]};
endmodule

//--- test/mgmt_packet_filter_regs_bench.sv
// Self-checking bench for the management filter bank.
// Assumes a 50 MHz clock and one-cycle answers.
`timescale 1ns/1ps
module mgmt_packet_filter_regs_bench;
    import mgmt_filter_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    reg_req_t bmc = '0;
    reg_req_t host = '0;
    logic ee = 1'b0, permit = 1'b0, fw = 1'b0, prst = 1'b0, iso = 1'b0, iso_st = 1'b0;
    logic tx = 1'b0, phy = 1'b0, send = 1'b0;
    logic [15:0] ee_a = 16'h5890;
    logic [31:0] ee_d = 32'h10;
    rx_pkt_t pkt = '0;
    rx_pkt_t rx;
    decision_t dec;
    logic back, hack, disc, irq, tx_o, phy_o, phy_p, hold;
    logic [31:0] rdata, hrd;
    logic [15:0] ph;
    logic [7:0] err;
    int bad_count = 0;
    int cmp_count = 0;
    logic [15:0] adr [8] = '{16'h502c, 16'h5030, 16'h5060, 16'h5864, 16'h5890, 16'h5930,
        16'h5820, 16'h5000};
    logic [31:0] exp [8] = '{32'hfff, 32'hffffffff, 32'h4000ffff, 32'hff, 32'hffffffff,
        32'hf, 32'h07820000, 32'h0};
    always #10 clk = ~clk;
    mgmt_rx_source u_mgmt_rx_source (.i_send(send), .i_pkt(pkt), .o_pkt(rx));
    mgmt_packet_filter_regs u_mgmt_packet_filter_regs (.i_core_clk(clk), .i_resetn(rstn),
        .i_bmc_req(bmc), .o_bmc_ack(back), .o_bmc_rdata(rdata), .i_host_req(host),
        .o_host_ack(hack), .o_host_rdata(hrd), .o_host_wr_discard(disc), .i_eeprom_wr(ee),
        .i_eeprom_addr(ee_a), .i_eeprom_data(ee_d), .o_eeprom_ready(),
        .i_phy_hold_permit(permit), .i_firmware_reset_seen(fw), .i_port_reset(prst),
        .i_isolate_cmd(iso), .i_isolate_state(iso_st), .o_mgmt_interrupt_cause(irq),
        .o_fw_extended_error_code(err), .i_rx_pkt(rx), .o_decision(dec), .o_port_hits(ph),
        .i_bmc_tx_valid(tx), .o_bmc_tx_valid(tx_o), .i_phy_reset_req(phy),
        .i_phy_power_req(phy), .o_phy_reset(phy_o), .o_phy_power_req(phy_p),
        .o_phy_hold_link(hold));
    task chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task bus(input logic hs, input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        if (hs) host = '{wr, !wr, a, d};
        else bmc = '{wr, !wr, a, d};
        @(posedge clk);
        #1;
        host = '0;
        bmc = '0;
        chk({31'h0, hs ? hack : back}, 32'h1);
    endtask
    task rd(input logic [15:0] a, input logic [31:0] want);
        bus(1'b0, 1'b0, a, '0);
        chk(rdata, want);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1;
        s = 1'b1;
        @(posedge clk);
        #1;
        s = 1'b0;
    endtask
    task pk(input logic [7:0] nd, input logic [9:0] want);
        @(posedge clk);
        #1;
        pkt = '{valid: 1'b1, bcast: 1'b1, mcast: 1'b1, icmpv6: 1'b1, icmpv6_type: nd,
            l4_valid: 1'b1, dst_port: 16'h1234, csum_ok: 1'b1, default: '0};
        send = 1'b1;
        @(posedge clk);
        #1;
        send = 1'b0;
        chk({22'h0, dec.to_mgmt, dec.withhold_host, dec.hits}, {22'h0, want});
        chk({16'h0, ph}, 32'h4);
    endtask
    task report_and_stop;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        rd(16'h5820, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 1'b1, adr[i], 32'hffffffff);
            bus(1'b1, 1'b1, adr[i], 32'h0);
            rd(adr[i], exp[i]);
        end
        bus(1'b1, 1'b0, 16'h502c, '0);
        chk(hrd, 32'hfff);
        pulse(fw);
        rd(16'h5864, 32'h0);
        rd(16'h5030, 32'hffffffff);
        pulse(prst);
        rd(16'h5820, 32'h07834000);
        bus(1'b0, 1'b1, 16'h5820, 32'h0);
        rd(16'h5820, 32'h0);
        permit = 1'b1;
        bus(1'b0, 1'b1, 16'h5820, 32'h40000);
        phy = 1'b1;
        rd(16'h5820, 32'h40000);
        chk({hold, phy_o, phy_p}, 32'h4);
        bus(1'b0, 1'b1, 16'h5820, 32'h0);
        @(posedge clk);
        #1;
        chk({phy_o, phy_p}, 32'h3);
        phy = 1'b0;
        iso_st = 1'b1;
        pulse(iso);
        chk({irq, err, disc}, {22'h0, 10'h21d});
        rd(16'h5820, 32'h8000);
        ee = 1'b1;
        bus(1'b0, 1'b1, 16'h5864, 32'h1);
        ee = 1'b0;
        bus(1'b0, 1'b1, 16'h5820, 32'h20000);
        bus(1'b0, 1'b1, 16'h5034, 32'h3412);
        tx = 1'b1;
        pk(8'h0, 10'h301);
        chk(tx_o, 32'h1);
        bus(1'b0, 1'b1, 16'h5890, 32'h04000000);
        pk(8'h0, 10'h000);
        bus(1'b0, 1'b1, 16'h5890, 32'h20000000);
        for (int t = 8'h85; t < 8'h8b; t++) begin
            pk(t[7:0], (t >= 8'h86 && t <= 8'h89) ? 10'h301 : 10'h000);
        end
        bus(1'b0, 1'b1, 16'h5820, 32'h0);
        pk(8'h86, 10'h001);
        chk(tx_o, 32'h0);
        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        rd(16'h5030, 32'h0);
        report_and_stop();
    end
endmodule
